// ==== hdl/secp_regs.svh ====
`ifndef SECP_REGS_SVH
`define SECP_REGS_SVH
// ---------------------------------------------
// Array geometry
// ---------------------------------------------
`define SECP_WORDS 16
`define SECP_WORD_W 16
`define SECP_ADDR_W 4
`define SECP_OP_W 4
`define SECP_ERASED 16'hFFFF
// ---------------------------------------------
// Frame lengths in serial clocks
// ---------------------------------------------
`define SECP_CMD_BITS 9
`define SECP_READ_CLKS 26
`define SECP_WRITE_CLKS 25
// ---------------------------------------------
// Opcode fields
// ---------------------------------------------
`define SECP_TOP_READ 2'h2
`define SECP_TOP_WRITE 2'h1
`define SECP_TOP_ERASE 2'h3
`define SECP_OP_READ 4'h8
`define SECP_OP_WRITE 4'h4
`define SECP_OP_ERASE 4'hC
`define SECP_OP_ENABLE 4'h3
`define SECP_OP_DISABLE 4'h0
`define SECP_OP_ERASE_ALL 4'h2
`define SECP_OP_WRITE_ALL 4'h1
// ---------------------------------------------
// Timing
// ---------------------------------------------
`define SECP_CLK_NS 40
`define SECP_SCLK_PERIOD_NS 4000
`define SECP_SCLK_HALF_CYC ((`SECP_SCLK_PERIOD_NS / 2 + `SECP_CLK_NS - 1) / `SECP_CLK_NS)
`define SECP_GAP_NS 1000
`define SECP_GAP_CYC ((`SECP_GAP_NS + `SECP_CLK_NS - 1) / `SECP_CLK_NS)
`define SECP_PULSE_MS 10
`define SECP_PULSE_CYC ((`SECP_PULSE_MS * 1000000 + `SECP_CLK_NS - 1) / `SECP_CLK_NS)
`endif

// ==== hdl/secp_pkg.sv ====
`include "secp_regs.svh"
package secp_pkg;
   // ---------------------------------------------
   // Types
   // ---------------------------------------------
   // Host-side command kinds
   typedef enum logic [2:0] {
      SECP_CMD_READ, SECP_CMD_WRITE, SECP_CMD_ERASE, SECP_CMD_ENABLE,
      SECP_CMD_DISABLE, SECP_CMD_ERASE_ALL, SECP_CMD_WRITE_ALL
   } secp_cmd_type;
   // Device link-side states
   typedef enum logic [2:0] {
      SECP_L_IDLE, SECP_L_CMD, SECP_L_DATA, SECP_L_READ, SECP_L_DONE
   } secp_link_state_type;
   // Host sequencer states
   typedef enum logic [2:0] {
      SECP_H_IDLE, SECP_H_ARM, SECP_H_SHIFT, SECP_H_PROG, SECP_H_END, SECP_H_GAP
   } secp_host_state_type;
   // ---------------------------------------------
   // Opcode decode
   // ---------------------------------------------
   // Read of one word, low opcode bits ignored
   function automatic logic secp_is_read(input logic [3:0] op);
      return op[3:2] == `SECP_TOP_READ;
   endfunction
   // Opcodes followed by a data word
   function automatic logic secp_has_data(input logic [3:0] op);
      return (op[3:2] == `SECP_TOP_WRITE) || (op == `SECP_OP_WRITE_ALL);
   endfunction
   // Opcodes that alter the array
   function automatic logic secp_is_prog(input logic [3:0] op);
      return !secp_is_read(op) && (op != `SECP_OP_ENABLE) && (op != `SECP_OP_DISABLE);
   endfunction
endpackage

// ==== hdl/secp_link_if.sv ====
`timescale 1ns/1ps
interface secp_link_if;
   // Select, clock and data from the host
   logic select;
   logic serial_clock;
   logic serial_in;
   // Device output driver and its enable (low = driving)
   logic so_data;
   logic so_oe_n;
   // Resolved output wire as the host sees it; a released line reads
   // as the inverse of so_data, which the device clears at release, so it reads one
   wire serial_out;
   assign serial_out = so_oe_n ? ~so_data : so_data;
   // Device end
   modport device (
      input select,
      input serial_clock,
      input serial_in,
      output so_data,
      output so_oe_n
   );
   // Host end
   modport host (
      output select,
      output serial_clock,
      output serial_in,
      input serial_out
   );
endinterface

// ==== hdl/secp_device.sv ====
// Overview of operation
// - Sixteen words of sixteen bits, 4-bit address
// - Every instruction is nine bits long
// - First bit is a one start marker
// - Then opcode and address, four bits each
// - Upper opcode 10/01/11 read, write, erase
// - 0011 enables programming, 0000 disables it
// - 0010 erases all, 0001 writes all
// - One clock after select before instruction bits
// - Output driven only during reads
// - Read loads word into 16-bit shifter
// - Zero dummy bit precedes read data
// - Output changes only on rising clock
// - Programming refused until enable executed
// - Enable persists until disable command
// - Reads work regardless of enable latch
// - Select low one microsecond between instructions
// - Serial clock period at least four microseconds
// - Programming pulse 10 to 30 ms
// - Select drop starts programming, erase sets ones
// - Write followed by sixteen data bits
// - End programming with select high one period
// - Clock may idle during programming pulse
`timescale 1ns/1ps
`include "secp_regs.svh"
module secp_device (
   // Core clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Serial link
   secp_link_if.device link,
   // Status
   output logic program_enabled_o,
   output logic busy_o
);
   import secp_pkg::*;

   // ---------------------------------------------
   // Storage, core domain
   // ---------------------------------------------
   logic [`SECP_WORD_W-1:0] mem [`SECP_WORDS];

   // ---------------------------------------------
   // Link domain registers
   // ---------------------------------------------
   logic [1:0] lrst_sync; // Reset carried into link domain
   logic link_rst_n; // Synchronised reset
   secp_link_state_type lstate; // Receiver state
   logic armed; // One clock seen with select high
   logic [3:0] cnt; // Bit counter
   logic [7:0] instr; // Opcode and address
   logic [`SECP_WORD_W-1:0] wdata; // Incoming data word
   logic [`SECP_WORD_W-1:0] rd_shift; // Outgoing read word
   logic [7:0] post_instr; // Command handed to core
   logic [`SECP_WORD_W-1:0] post_data; // Data handed to core
   logic post_tgl; // Toggles once per non-read command
   logic so_data; // Output bit
   logic so_oe_n; // Output enable, low drives
   logic [7:0] next_instr; // Instruction with current bit

   assign link_rst_n = lrst_sync[1];
   assign next_instr = {instr[6:0], link.serial_in};
   assign link.so_data = so_data;
   assign link.so_oe_n = so_oe_n;

   // Reset synchroniser: asserts at once, releases on the second link clock.
   // The link clock runs only in frames, so a clocked reset never lands.
   always_ff @(posedge link.serial_clock or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lrst_sync <= 2'h0;
      end else begin
         lrst_sync <= {lrst_sync[0], 1'b1};
      end
   end

   // Receiver sequence; select low clears it at once, since no clock
   // runs between frames to carry a clocked clear
   always_ff @(posedge link.serial_clock or negedge link.select) begin
      if (!link.select) begin
         // Abandon any partial frame
         lstate <= SECP_L_IDLE;
         armed <= 1'b0;
         cnt <= 4'h0;
      end else begin
         case (lstate)
            SECP_L_IDLE: begin
               // First clock after select only arms the port
               armed <= 1'b1;
               if (armed && link.serial_in) begin
                  lstate <= SECP_L_CMD;
                  cnt <= 4'h0;
               end
            end
            SECP_L_CMD: begin
               // Eight bits after the marker, MSB first
               cnt <= cnt + 4'h1;
               if (cnt == 4'h7) begin
                  cnt <= 4'h0;
                  // Decode on the ninth bit
                  if (secp_is_read(next_instr[7:4])) begin
                     lstate <= SECP_L_READ;
                  end else if (secp_has_data(next_instr[7:4])) begin
                     lstate <= SECP_L_DATA;
                  end else begin
                     lstate <= SECP_L_DONE;
                  end
               end
            end
            SECP_L_DATA: begin
               // Sixteen data bits
               cnt <= cnt + 4'h1;
               if (cnt == 4'hF) begin
                  lstate <= SECP_L_DONE;
               end
            end
            SECP_L_READ: begin
               // Sixteen output bits
               cnt <= cnt + 4'h1;
               if (cnt == 4'hF) begin
                  lstate <= SECP_L_DONE;
               end
            end
            default: begin
               // Extra clocks ignored until select drops
               lstate <= SECP_L_DONE;
            end
         endcase
      end
   end

   // Instruction and data shifters
   always_ff @(posedge link.serial_clock) begin
      if (!link_rst_n) begin
         instr <= 8'h00;
         wdata <= '0;
      end else if (lstate == SECP_L_CMD) begin
         instr <= next_instr;
      end else if (lstate == SECP_L_DATA) begin
         wdata <= {wdata[`SECP_WORD_W-2:0], link.serial_in};
      end
   end

   // Hand a finished command to the core; held stable until the next one
   always_ff @(posedge link.serial_clock) begin
      if (!link_rst_n) begin
         post_instr <= 8'h00;
         post_data <= '0;
         post_tgl <= 1'b0;
      end else if (link.select) begin
         if (lstate == SECP_L_CMD && cnt == 4'h7 && !secp_is_read(next_instr[7:4])
             && !secp_has_data(next_instr[7:4])) begin
            post_instr <= next_instr;
            post_tgl <= ~post_tgl;
         end else if (lstate == SECP_L_DATA && cnt == 4'hF) begin
            post_instr <= instr;
            post_data <= {wdata[`SECP_WORD_W-2:0], link.serial_in};
            post_tgl <= ~post_tgl;
         end
      end
   end

   // Read output path; array is only altered while select is low,
   // so the word read here is quiet across the domain boundary
   always_ff @(posedge link.serial_clock or negedge link.select) begin
      if (!link.select) begin
         so_oe_n <= 1'b1;
         so_data <= 1'b0;
         rd_shift <= '0;
      end else if (lstate == SECP_L_CMD && cnt == 4'h7
                   && secp_is_read(next_instr[7:4])) begin
         rd_shift <= mem[next_instr[3:0]];
         so_data <= 1'b0;
         so_oe_n <= 1'b0;
      end else if (lstate == SECP_L_READ) begin
         so_data <= rd_shift[`SECP_WORD_W-1];
         rd_shift <= {rd_shift[`SECP_WORD_W-2:0], 1'b0};
      end else begin
         // Release after the last data bit
         so_oe_n <= 1'b1;
         so_data <= 1'b0;
      end
   end

   // ---------------------------------------------
   // Core domain
   // ---------------------------------------------
   logic [1:0] sel_sync; // Select synchroniser
   logic [1:0] tgl_sync; // Command toggle synchroniser
   logic tgl_seen; // Last toggle acted on
   logic pending; // Command waiting for select drop
   logic [7:0] c_instr; // Core copy of command
   logic [`SECP_WORD_W-1:0] c_data; // Core copy of data
   logic enable_latch; // Programming enable
   logic busy; // Programming cycle in progress
   logic new_cmd; // Toggle edge seen
   logic exec; // Carry out pending command
   logic [3:0] c_op; // Opcode view
   logic [3:0] c_addr; // Address view

   assign new_cmd = tgl_sync[1] != tgl_seen;
   assign exec = pending && !sel_sync[1];
   assign c_op = c_instr[7:4];
   assign c_addr = c_instr[3:0];
   assign program_enabled_o = enable_latch;
   assign busy_o = busy;

   // Bring select and toggle across
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         sel_sync <= 2'h0;
         tgl_sync <= 2'h0;
         tgl_seen <= 1'b0;
      end else begin
         sel_sync <= {sel_sync[0], link.select};
         tgl_sync <= {tgl_sync[0], post_tgl};
         tgl_seen <= tgl_sync[1];
      end
   end

   // Capture command; a new arrival wins over the clear
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         pending <= 1'b0;
         c_instr <= 8'h00;
         c_data <= '0;
      end else begin
         pending <= (pending && !exec) || new_cmd;
         if (new_cmd) begin
            c_instr <= post_instr;
            c_data <= post_data;
         end
      end
   end

   // Enable latch, cleared only by reset or the disable command
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         enable_latch <= 1'b0;
      end else if (exec && c_op == `SECP_OP_ENABLE) begin
         enable_latch <= 1'b1;
      end else if (exec && c_op == `SECP_OP_DISABLE) begin
         enable_latch <= 1'b0;
      end
   end

   // Array update at the select drop, refused while disabled
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < `SECP_WORDS; i++) begin
            mem[i] <= `SECP_ERASED;
         end
      end else if (exec && enable_latch) begin
         if (c_op[3:2] == `SECP_TOP_WRITE) begin
            mem[c_addr] <= c_data;
         end else if (c_op[3:2] == `SECP_TOP_ERASE) begin
            mem[c_addr] <= `SECP_ERASED;
         end else if (c_op == `SECP_OP_ERASE_ALL) begin
            for (int i = 0; i < `SECP_WORDS; i++) begin
               mem[i] <= `SECP_ERASED;
            end
         end else if (c_op == `SECP_OP_WRITE_ALL) begin
            for (int i = 0; i < `SECP_WORDS; i++) begin
               mem[i] <= c_data;
            end
         end
      end
   end

   // Busy from select drop until select returns high
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         busy <= 1'b0;
      end else if (exec && enable_latch && secp_is_prog(c_op)) begin
         busy <= 1'b1;
      end else if (sel_sync[1]) begin
         busy <= 1'b0;
      end
   end
endmodule

// ==== hdl/secp_host.sv ====
`timescale 1ns/1ps
`include "secp_regs.svh"
module secp_host #(
   parameter int PULSE_CYC = `SECP_PULSE_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Command request
   input wire logic cmd_valid_i,
   input secp_pkg::secp_cmd_type cmd_kind_i,
   input wire logic [`SECP_ADDR_W-1:0] cmd_addr_i,
   input wire logic [`SECP_WORD_W-1:0] cmd_data_i,
   output logic cmd_ready_o,
   // Read answer
   output logic [`SECP_WORD_W-1:0] rd_data_o,
   output logic rd_valid_o,
   // Serial link
   secp_link_if.host link
);
   import secp_pkg::*;

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   // Opcode for a command kind
   function automatic logic [3:0] op_of(input secp_cmd_type k);
      case (k)
         SECP_CMD_READ: return `SECP_OP_READ;
         SECP_CMD_WRITE: return `SECP_OP_WRITE;
         SECP_CMD_ERASE: return `SECP_OP_ERASE;
         SECP_CMD_ENABLE: return `SECP_OP_ENABLE;
         SECP_CMD_DISABLE: return `SECP_OP_DISABLE;
         SECP_CMD_ERASE_ALL: return `SECP_OP_ERASE_ALL;
         default: return `SECP_OP_WRITE_ALL;
      endcase
   endfunction

   // ---------------------------------------------
   // Registers
   // ---------------------------------------------
   localparam logic [6:0] HALF = 7'(`SECP_SCLK_HALF_CYC);
   localparam logic [19:0] PULSE = 20'(PULSE_CYC);
   secp_host_state_type state; // Sequencer state
   logic [6:0] half_cnt; // Half period counter
   logic [19:0] wait_cnt; // Pulse and gap counter
   logic [4:0] clks_left; // Serial clocks still to send
   logic [24:0] frame; // Marker, opcode, address, data
   logic [3:0] op; // Opcode of this command
   logic [1:0] so_sync; // Serial output synchroniser
   logic sclk, sel, si; // Pin flops
   logic tick; // End of a half period

   assign tick = half_cnt == HALF - 7'h1;
   assign link.serial_clock = sclk;
   assign link.select = sel;
   assign link.serial_in = si;

   // Device output is asynchronous to this clock
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         so_sync <= 2'h0;
      end else begin
         so_sync <= {so_sync[0], link.serial_out};
      end
   end

   // Sequencer and pins
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         state <= SECP_H_IDLE;
         {sclk, sel, si} <= 3'h0;
         half_cnt <= 7'h00;
         wait_cnt <= 20'h00000;
         clks_left <= 5'h00;
         frame <= '0;
         op <= 4'h0;
         cmd_ready_o <= 1'b1;
         rd_valid_o <= 1'b0;
         rd_data_o <= '0;
      end else begin
         rd_valid_o <= 1'b0;
         half_cnt <= (tick || state == SECP_H_IDLE) ? 7'h00 : half_cnt + 7'h1;
         case (state)
            SECP_H_IDLE: begin
               if (cmd_valid_i && cmd_ready_o) begin
                  cmd_ready_o <= 1'b0;
                  op <= op_of(cmd_kind_i);
                  frame <= {1'b1, op_of(cmd_kind_i), cmd_addr_i, cmd_data_i};
                  sel <= 1'b1;
                  state <= SECP_H_ARM;
               end
            end
            SECP_H_ARM: begin
               // One idle clock before the marker
               if (tick) begin
                  sclk <= ~sclk;
                  if (sclk) begin
                     si <= frame[24];
                     state <= SECP_H_SHIFT;
                     if (secp_is_read(op)) begin
                        clks_left <= 5'(`SECP_READ_CLKS);
                     end else if (secp_has_data(op)) begin
                        clks_left <= 5'(`SECP_WRITE_CLKS);
                     end else begin
                        clks_left <= 5'(`SECP_CMD_BITS);
                     end
                  end
               end
            end
            SECP_H_SHIFT: begin
               if (tick) begin
                  sclk <= ~sclk;
                  if (!sclk) begin
                     // Sample just before the rising edge
                     rd_data_o <= {rd_data_o[`SECP_WORD_W-2:0], so_sync[1]};
                  end else if (clks_left == 5'h01) begin
                     sel <= 1'b0;
                     si <= 1'b0;
                     rd_valid_o <= secp_is_read(op);
                     wait_cnt <= secp_is_prog(op) ? PULSE : 20'(`SECP_GAP_CYC);
                     state <= secp_is_prog(op) ? SECP_H_PROG : SECP_H_GAP;
                  end else begin
                     clks_left <= clks_left - 5'h01;
                     frame <= {frame[23:0], 1'b0};
                     si <= frame[23];
                  end
               end
            end
            SECP_H_PROG: begin
               // Clock idles through the pulse
               wait_cnt <= wait_cnt - 20'h00001;
               if (wait_cnt == 20'h00001) begin
                  sel <= 1'b1;
                  wait_cnt <= 20'({HALF, 1'b0});
                  state <= SECP_H_END;
               end
            end
            SECP_H_END: begin
               wait_cnt <= wait_cnt - 20'h00001;
               if (wait_cnt == 20'h00001) begin
                  sel <= 1'b0;
                  wait_cnt <= 20'(`SECP_GAP_CYC);
                  state <= SECP_H_GAP;
               end
            end
            default: begin
               // Select stays low between instructions
               wait_cnt <= wait_cnt - 20'h00001;
               if (wait_cnt == 20'h00001) begin
                  cmd_ready_o <= 1'b1;
                  state <= SECP_H_IDLE;
               end
            end
         endcase
      end
   end
endmodule

// ==== tb/secp_assertions.sv ====
`timescale 1ns/1ps
module secp_assertions (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Link wires
   input wire logic select,
   input wire logic serial_clock,
   input wire logic serial_in,
   input wire logic so_data,
   input wire logic so_oe_n
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // ---------------------------------------------
   // Helper state
   // ---------------------------------------------
   logic sclk_q; // Serial clock last cycle
   logic sel_q; // Select last cycle
   logic seen; // Output enable known only after a first frame
   logic [7:0] sel_cnt; // Clock rises since select rose
   logic [7:0] drv_cnt; // Clock rises while driving
   logic [7:0] low_cnt; // Select low cycles, saturating
   logic [7:0] per_cnt; // Cycles since last rise, saturating
   wire sclk_rise = serial_clock & ~sclk_q;
   // Edge history
   always_ff @(posedge clk_i) begin
      sclk_q <= serial_clock;
      sel_q <= select;
      if (!reset_n_i) seen <= 1'b0;
      else if (sel_q && !select) seen <= 1'b1;
   end
   // Frame and drive counters
   always_ff @(posedge clk_i) begin
      if (!select) sel_cnt <= 8'h00;
      else if (sclk_rise) sel_cnt <= sel_cnt + 8'h01;
      if (so_oe_n || !seen) drv_cnt <= 8'h00;
      else if (sclk_rise) drv_cnt <= drv_cnt + 8'h01;
   end
   // Saturating, so a long idle never wraps into a false short gap
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) low_cnt <= 8'hFF;
      else if (select) low_cnt <= 8'h00;
      else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
      if (!reset_n_i) per_cnt <= 8'hFF;
      else if (sclk_rise) per_cnt <= 8'h00;
      else if (per_cnt != 8'hFF) per_cnt <= per_cnt + 8'h01;
   end
   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   a_out_idle: assert property (seen && !select |-> so_oe_n)
      else $error("serial output driven with select low");
   a_out_on_rise: assert property (seen && $changed(so_data) |-> $rose(serial_clock))
      else $error("output bit changed without a clock rise");
   a_release_on_rise: assert property (seen && $rose(so_oe_n) |-> $rose(serial_clock))
      else $error("output released without a clock rise");
   a_dummy_zero: assert property (seen && $fell(so_oe_n) |-> !so_data)
      else $error("dummy bit not zero");
   a_drive_start: assert property (seen && $fell(so_oe_n) |-> sel_cnt == 8'h09)
      else $error("read output began at wrong bit");
   a_drive_length: assert property (seen && $rose(so_oe_n) |-> drv_cnt == 8'h11)
      else $error("read output not dummy plus sixteen bits");
   a_select_gap: assert property ($rose(select) |-> low_cnt >= 8'h19)
      else $error("select low gap too short");
   a_clock_period: assert property ($rose(serial_clock) |-> per_cnt >= 8'h63)
      else $error("serial clock period too short");
   a_in_on_low: assert property ($changed(serial_in) |-> !serial_clock)
      else $error("serial input changed while clock high");
   a_start_after_arm: assert property (select && $rose(serial_in) |-> sel_cnt != 8'h00)
      else $error("instruction bit sent before the arming clock");
   a_clock_idle: assert property (!select |-> !serial_clock)
      else $error("serial clock high with select low");
   a_prog_end_high: assert property ($fell(select) && sel_cnt == 8'h00 |-> $past(select, 99))
      else $error("select high too briefly after a programming pulse");
   // Main scenarios
   c_read: cover property (seen && $fell(so_oe_n));
   c_release: cover property (seen && $rose(so_oe_n));
   c_pulse: cover property ($rose(select) && low_cnt > 8'h96 && low_cnt != 8'hFF);
endmodule

// ==== tb/serial_eeprom_cmd_port_tb.sv ====
`timescale 1ns/1ps
module serial_eeprom_cmd_port_tb;
   import secp_pkg::*;
   localparam int PULSE = 200; // Short pulse keeps the run brief
   // ---------------------------------------------
   // Stimulus and observed signals
   // ---------------------------------------------
   logic clk_i = 1'b0;
   logic reset_n_i; // Lowered at time zero so the link reset sees an edge
   logic cmd_valid_i = 1'b0;
   secp_cmd_type cmd_kind_i = SECP_CMD_READ;
   logic [3:0] cmd_addr_i = 4'h0;
   logic [15:0] cmd_data_i = 16'h0000;
   logic cmd_ready_o;
   logic rd_valid_o;
   logic [15:0] rd_data_o;
   logic program_enabled_o;
   logic busy_o;
   logic [15:0] mem [16]; // Expected array
   logic en = 1'b0; // Expected enable latch
   logic busy_seen = 1'b0; // Busy seen during a command
   int n_fail = 0;
   int check_count = 0;
   int seed = 32'hA147;
   secp_link_if u_secp_link_if ();
   secp_device u_secp_device (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .link(u_secp_link_if.device), .program_enabled_o(program_enabled_o), .busy_o(busy_o));
   secp_host #(.PULSE_CYC(PULSE)) u_secp_host (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .cmd_valid_i(cmd_valid_i), .cmd_kind_i(cmd_kind_i), .cmd_addr_i(cmd_addr_i),
      .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o), .rd_data_o(rd_data_o),
      .rd_valid_o(rd_valid_o), .link(u_secp_link_if.host));
   secp_assertions chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .select(u_secp_link_if.select), .serial_clock(u_secp_link_if.serial_clock),
      .serial_in(u_secp_link_if.serial_in), .so_data(u_secp_link_if.so_data),
      .so_oe_n(u_secp_link_if.so_oe_n));
   // 25 MHz clock
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   // Latch any busy pulse
   always @(posedge clk_i) begin
      if (busy_o === 1'b1) busy_seen = 1'b1;
   end
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   function automatic logic is_prog(input secp_cmd_type k);
      return k inside {SECP_CMD_WRITE, SECP_CMD_ERASE, SECP_CMD_ERASE_ALL, SECP_CMD_WRITE_ALL};
   endfunction
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   // One command, then compare read data, busy and latch
   task automatic run(input secp_cmd_type kind, input logic [3:0] addr, input logic [15:0] data);
      @(posedge clk_i);
      while (cmd_ready_o !== 1'b1) @(posedge clk_i);
      busy_seen = 1'b0;
      cmd_valid_i <= 1'b1;
      cmd_kind_i <= kind;
      cmd_addr_i <= addr;
      cmd_data_i <= data;
      @(posedge clk_i);
      cmd_valid_i <= 1'b0;
      if (kind == SECP_CMD_READ) begin
         while (rd_valid_o !== 1'b1) @(posedge clk_i);
         check("read word", mem[addr], rd_data_o);
      end
      @(posedge clk_i);
      while (cmd_ready_o !== 1'b1) @(posedge clk_i);
      // Refused commands must leave busy low
      check("busy", {15'h0000, is_prog(kind) && en}, {15'h0000, busy_seen});
      if (is_prog(kind) && en) begin
         for (int i = 0; i < 16; i++) begin
            if (kind == SECP_CMD_ERASE_ALL || (kind == SECP_CMD_ERASE && i == addr))
               mem[i] = 16'hFFFF;
            if (kind == SECP_CMD_WRITE_ALL || (kind == SECP_CMD_WRITE && i == addr))
               mem[i] = data;
         end
      end
      if (kind == SECP_CMD_ENABLE) en = 1'b1;
      if (kind == SECP_CMD_DISABLE) en = 1'b0;
      check("enable latch", {15'h0000, en}, {15'h0000, program_enabled_o});
   endtask
   task automatic conclude;
      if (n_fail == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      logic [3:0] a;
      logic [15:0] d;
      int k;
      reset_n_i <= 1'b0;
      for (int i = 0; i < 16; i++) mem[i] = 16'hFFFF;
      repeat (20) @(posedge clk_i);
      reset_n_i <= 1'b1;
      run(SECP_CMD_READ, 4'h5, 16'h0000);
      run(SECP_CMD_WRITE, 4'h5, 16'h1234);
      run(SECP_CMD_READ, 4'h5, 16'h0000);
      run(SECP_CMD_ENABLE, 4'hA, 16'h0000);
      run(SECP_CMD_WRITE, 4'hF, 16'h0000);
      run(SECP_CMD_READ, 4'hF, 16'h0000);
      run(SECP_CMD_WRITE, 4'h0, 16'h8001);
      run(SECP_CMD_READ, 4'h0, 16'h0000);
      // Random mix of word commands, each read back
      repeat (6) begin
         a = $random(seed);
         d = $random(seed);
         k = {$random(seed)} % 3;
         run(k == 0 ? SECP_CMD_WRITE : (k == 1 ? SECP_CMD_ERASE : SECP_CMD_READ), a, d);
         run(SECP_CMD_READ, a, 16'h0000);
      end
      run(SECP_CMD_ERASE_ALL, 4'h3, 16'h0000);
      run(SECP_CMD_READ, 4'hF, 16'h0000);
      run(SECP_CMD_WRITE_ALL, 4'h0, 16'h5AC3);
      run(SECP_CMD_READ, 4'h9, 16'h0000);
      run(SECP_CMD_DISABLE, 4'h7, 16'h0000);
      run(SECP_CMD_ERASE, 4'h9, 16'h0000);
      run(SECP_CMD_READ, 4'h9, 16'h0000);
      conclude();
   end
   // Watchdog, well beyond the expected run
   initial begin
      repeat (95000) @(posedge clk_i);
      n_fail++;
      conclude();
   end
endmodule
